// *** logic/alarm_filter_rate_map.svh ***
`ifndef ALARM_FILTER_RATE_MAP_SVH
`define ALARM_FILTER_RATE_MAP_SVH

// ==========================================
// Byte addresses of the register words
`define SYSTEM_ALARM_THRESHOLD_ADDR 7'h32
`define ALARM_CONTROL_ADDR         7'h34
`define AXIS_FILTER_SELECT_ADDR    7'h38
`define SAMPLE_RATE_SCALE_ADDR     7'h3A
`define DIAGNOSTIC_STATUS_ADDR     7'h3C
`define GLOBAL_COMMAND_ADDR        7'h3E

// ==========================================
// Reset values and writable masks
`define SYSTEM_ALARM_THRESHOLD_RESET 16'h0000
`define ALARM_CONTROL_RESET          16'h0080
`define AXIS_FILTER_SELECT_RESET     16'h0000
`define SAMPLE_RATE_SCALE_RESET      16'h7421
`define ALARM_CONTROL_MASK           16'h1FFF
`define AXIS_FILTER_SELECT_MASK      16'h0777

// ==========================================
// Alarm control fields
`define AXIS_ENABLE_LSB    0
`define SYSTEM_ENABLE_BIT  3
`define SOURCE_SELECT_BIT  4
`define POLARITY_BIT       5
`define ALARM_PINS_BIT     6
`define LATCH_FLAGS_BIT    7
`define DELAY_LSB          8
`define KEEP_ON_READ_BIT   12

// ==========================================
// Filter fields, status and command bits
`define FILTER_X_LSB        0
`define FILTER_Y_LSB        4
`define FILTER_Z_LSB        8
`define STATUS_SPECTRAL_LSB 8
`define STATUS_SYSTEM_BIT   14
`define CLEAR_STATUS_BIT    4
`define FIR_TAP_COUNT       32
`define FULL_RATE_SCALE     4'h1
`define MAX_RATE_SCALE      4'h7

`endif

// *** logic/alarm_filter_rate_pkg.sv ***
package alarm_filter_rate_pkg;

	// ==========================================
	// Link word and decoded selections
	typedef struct packed {
		logic       write_flag;
		logic [6:0] address;
		logic [7:0] data;
	} link_word_type;

	typedef enum logic [2:0] {
		filter_none      = 3'b000,
		filter_low_1k    = 3'b001,
		filter_low_5k    = 3'b010,
		filter_low_10k   = 3'b011,
		filter_high_1k   = 3'b100,
		filter_high_5k   = 3'b101,
		filter_high_10k  = 3'b110
	} filter_kind_type;

	typedef struct packed {
		filter_kind_type z_axis;
		filter_kind_type y_axis;
		filter_kind_type x_axis;
	} filter_choice_type;

	typedef struct packed {
		logic [3:0] scale;
		logic       applies;
		logic       valid;
		logic [2:0] bin_shift;
	} rate_choice_type;

endpackage : alarm_filter_rate_pkg

// *** logic/alarm_filter_rate_config_regs.sv ***
// Overview of operation
// - Hold sixteen-bit system alarm threshold, compare to measurement.
// - Bit 4 selects temperature or supply source.
// - Bit 5 trips below, else above threshold.
// - Bits 3..0 enable system, z, y, x alarms.
// - Bit 6 drives alarm levels onto pins.
// - Bit 7 latches flags until clear command; spectral ones also clear on read.
// - Four-bit delay counts records before spectral flag.
// - Bit 12 stops read auto-clearing spectral flags.
// - Filter select reset value means no filtering.
// - Three-bit filter field per axis.
// - Filter codes decode to none, low, high pass.
// - Every filter bank has thirty-two taps.
// - Sixteen-bit words write one byte each.
// - Four scale nibbles, first lowest, fourth highest.
// - Chosen rate applies only in three modes.
// - Scale one to seven halves rate; zero invalid.
// - Scale sets FFT bin width halving per step.
// - Writing one byte leaves other byte untouched.
// - System alarm condition sets status bit 14.
// - Clear command bit 4 clears status flags once.
`timescale 1ns/1ps
`include "alarm_filter_rate_map.svh"

module alarm_filter_rate_config_regs
	import alarm_filter_rate_pkg::*;
(
	input  wire logic              clk,
	input  wire logic              reset_n,
	input  wire logic              link_sclk,
	input  wire logic              link_cs_n,
	input  wire logic              link_mosi,
	output logic                   link_miso,
	output logic                   link_miso_oe_n,
	input  wire logic [15:0]       temperature_value,
	input  wire logic [15:0]       supply_value,
	input  wire logic              measurement_valid,
	input  wire logic              record_done,
	input  wire logic [5:0]        spectral_exceed,
	input  wire logic [1:0]        rate_setting_index,
	input  wire logic              manual_fft_mode,
	input  wire logic              automatic_fft_mode,
	input  wire logic              manual_time_capture_mode,
	output logic                   alarm_output_one,
	output logic                   alarm_output_two,
	output filter_choice_type      filter_choice,
	output rate_choice_type        rate_choice,
	output logic [15:0]            diagnostic_status
);

	// ==========================================
	// Link side, clocked by the host's serial clock
	// The bit counter is held clear by chip select so that each frame starts
	// aligned even though the serial clock stands still between frames.
	logic [3:0]    bit_count;
	logic [14:0]   shift_in;
	logic [15:0]   word_hold;
	logic          word_toggle;
	logic [15:0]   shift_out;
	logic [15:0]   read_word;

	always_ff @(posedge link_sclk or negedge reset_n or posedge link_cs_n) begin
		if (!reset_n || link_cs_n) begin
			bit_count <= 4'h0;
		end else begin
			bit_count <= bit_count + 4'h1;
		end
	end

	always_ff @(posedge link_sclk or negedge reset_n) begin
		if (!reset_n) begin
			shift_in    <= 15'h0000;
			word_hold   <= 16'h0000;
			word_toggle <= 1'b0;
		end else if (!link_cs_n) begin
			shift_in <= {shift_in[13:0], link_mosi};
			if (bit_count == 4'hF) begin
				word_hold   <= {shift_in, link_mosi};
				word_toggle <= ~word_toggle;
			end
		end
	end

	// The answer word is loaded on the first edge of the following frame;
	// it was settled in the gap between frames and is stable by then.
	always_ff @(posedge link_sclk or negedge reset_n) begin
		if (!reset_n) begin
			shift_out <= 16'h0000;
			link_miso <= 1'b0;
		end else if (bit_count == 4'h0) begin
			shift_out <= {read_word[14:0], 1'b0};
			link_miso <= read_word[15];
		end else begin
			shift_out <= {shift_out[14:0], 1'b0};
			link_miso <= shift_out[15];
		end
	end

	always_ff @(posedge link_sclk or negedge reset_n or posedge link_cs_n) begin
		if (!reset_n || link_cs_n) begin
			link_miso_oe_n <= 1'b1;
		end else begin
			link_miso_oe_n <= 1'b0;
		end
	end

	// ==========================================
	// Crossing of the word event into the core clock
	logic          toggle_meta;
	logic          toggle_mid;
	logic          toggle_late;
	logic          toggle_seen;

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			toggle_meta <= 1'b0;
			toggle_mid  <= 1'b0;
			toggle_late <= 1'b0;
			toggle_seen <= 1'b0;
		end else begin
			toggle_meta <= word_toggle;
			toggle_mid  <= toggle_meta;
			toggle_late <= toggle_mid;
			if (toggle_mid == toggle_late) begin
				toggle_seen <= toggle_late;
			end
		end
	end

	wire logic          word_event  = (toggle_mid == toggle_late) && (toggle_late != toggle_seen);
	wire link_word_type link_word   = word_hold;
	wire logic          write_event = word_event && link_word.write_flag;
	wire logic          read_event  = word_event && !link_word.write_flag;
	wire logic          high_byte   = link_word.address[0];
	wire logic [6:0]    word_addr   = {link_word.address[6:1], 1'b0};

	// ==========================================
	// Register file
	logic [15:0]   system_alarm_threshold;
	logic [15:0]   alarm_control;
	logic [15:0]   axis_filter_select;
	logic [15:0]   sample_rate_scale;

	wire logic hit_threshold = (word_addr == `SYSTEM_ALARM_THRESHOLD_ADDR);
	wire logic hit_control   = (word_addr == `ALARM_CONTROL_ADDR);
	wire logic hit_filter    = (word_addr == `AXIS_FILTER_SELECT_ADDR);
	wire logic hit_rate      = (word_addr == `SAMPLE_RATE_SCALE_ADDR);
	wire logic hit_status    = (word_addr == `DIAGNOSTIC_STATUS_ADDR);
	wire logic hit_command   = (word_addr == `GLOBAL_COMMAND_ADDR);

	// Only the addressed byte changes; the other byte keeps its value.
	function automatic logic [15:0] merge_byte(
		input logic [15:0] old_value,
		input logic        upper,
		input logic [7:0]  data,
		input logic [15:0] mask
	);
		logic [15:0] merged;
		merged = upper ? {data, old_value[7:0]} : {old_value[15:8], data};
		return merged & mask;
	endfunction : merge_byte

	wire logic [15:0] next_threshold = merge_byte(system_alarm_threshold, high_byte, link_word.data, 16'hFFFF);
	wire logic [15:0] next_control   = merge_byte(alarm_control, high_byte, link_word.data, `ALARM_CONTROL_MASK);
	wire logic [15:0] next_filter    = merge_byte(axis_filter_select, high_byte, link_word.data,
	                                              `AXIS_FILTER_SELECT_MASK);
	wire logic [15:0] next_rate      = merge_byte(sample_rate_scale, high_byte, link_word.data, 16'hFFFF);

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			system_alarm_threshold <= `SYSTEM_ALARM_THRESHOLD_RESET;
			alarm_control          <= `ALARM_CONTROL_RESET;
			axis_filter_select     <= `AXIS_FILTER_SELECT_RESET;
			sample_rate_scale      <= `SAMPLE_RATE_SCALE_RESET;
		end else if (write_event) begin
			if (hit_threshold) system_alarm_threshold <= next_threshold;
			if (hit_control)   alarm_control          <= next_control;
			if (hit_filter)    axis_filter_select     <= next_filter;
			if (hit_rate)      sample_rate_scale      <= next_rate;
		end
	end

	// Only the low byte of the command word carries the clear bit.
	wire logic clear_status = write_event && hit_command && !high_byte &&
	                          link_word.data[`CLEAR_STATUS_BIT];

	// ==========================================
	// Control fields
	wire logic [2:0] axis_enable    = alarm_control[`AXIS_ENABLE_LSB +: 3];
	wire logic       system_enable  = alarm_control[`SYSTEM_ENABLE_BIT];
	wire logic       use_temperature = alarm_control[`SOURCE_SELECT_BIT];
	wire logic       trip_below     = alarm_control[`POLARITY_BIT];
	wire logic       drive_pins     = alarm_control[`ALARM_PINS_BIT];
	wire logic       latch_flags    = alarm_control[`LATCH_FLAGS_BIT];
	wire logic [3:0] response_delay = alarm_control[`DELAY_LSB +: 4];
	wire logic       keep_on_read   = alarm_control[`KEEP_ON_READ_BIT];

	// ==========================================
	// System alarm
	// Temperature is two's complement while supply is unsigned, so the
	// comparison changes signedness together with the source.
	wire logic [15:0] measurement = use_temperature ? temperature_value : supply_value;
	wire logic        meas_below  = use_temperature ?
	                                ($signed(measurement) < $signed(system_alarm_threshold)) :
	                                (measurement < system_alarm_threshold);
	wire logic        meas_above  = use_temperature ?
	                                ($signed(measurement) > $signed(system_alarm_threshold)) :
	                                (measurement > system_alarm_threshold);
	wire logic        system_trip = trip_below ? meas_below : meas_above;
	wire logic        system_set  = measurement_valid && system_enable && system_trip;
	wire logic        system_keep = latch_flags || !measurement_valid;

	logic system_flag;

	// A new trip in the cycle of a clear still leaves the flag set.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			system_flag <= 1'b0;
		end else begin
			system_flag <= system_set || (system_flag && system_keep && !clear_status);
		end
	end

	// ==========================================
	// Spectral alarm flags, x/y/z level one then x/y/z level two
	wire logic status_read = read_event && hit_status;
	wire logic read_clear  = status_read && !keep_on_read;

	logic [5:0] spectral_flag;

	genvar g;
	generate
		for (g = 0; g < 6; g = g + 1) begin : gen_spectral
			logic [3:0] record_count;
			wire logic  armed    = axis_enable[g % 3] && spectral_exceed[g];
			wire logic  reached  = (record_count >= response_delay);
			wire logic  flag_set = record_done && armed && reached;
			wire logic  keep     = latch_flags || !(record_done && !armed);
			wire logic  clear    = clear_status || read_clear;

			always_ff @(posedge clk or negedge reset_n) begin
				if (!reset_n) begin
					record_count <= 4'h0;
				end else if (record_done) begin
					if (!armed) begin
						record_count <= 4'h0;
					end else if (record_count != 4'hF) begin
						record_count <= record_count + 4'h1;
					end
				end
			end

			always_ff @(posedge clk or negedge reset_n) begin
				if (!reset_n) begin
					spectral_flag[g] <= 1'b0;
				end else begin
					spectral_flag[g] <= flag_set || (spectral_flag[g] && keep && !clear);
				end
			end
		end
	endgenerate

	// ==========================================
	// Status word and read answer
	wire logic [15:0] status_word = {1'b0, system_flag, spectral_flag, 8'h00};

	wire logic [15:0] read_select =
		hit_threshold ? system_alarm_threshold :
		hit_control   ? alarm_control :
		hit_filter    ? axis_filter_select :
		hit_rate      ? sample_rate_scale :
		hit_status    ? status_word :
		16'h0000;

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			read_word         <= 16'h0000;
			diagnostic_status <= 16'h0000;
		end else begin
			if (read_event) begin
				read_word <= read_select;
			end
			diagnostic_status <= status_word;
		end
	end

	// ==========================================
	// Alarm pins
	wire logic any_level_one = |spectral_flag[2:0];
	wire logic any_level_two = |spectral_flag[5:3];

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			alarm_output_one <= 1'b0;
			alarm_output_two <= 1'b0;
		end else begin
			alarm_output_one <= drive_pins && any_level_one;
			alarm_output_two <= drive_pins && any_level_two;
		end
	end

	// ==========================================
	// Filter bank selection
	// Each selection feeds a bank of FIR_TAP_COUNT taps held by the filter
	// engine; only the choice of bank lives here.
	function automatic filter_kind_type decode_filter(input logic [2:0] code);
		filter_kind_type kind;
		unique case (code)
			3'b001:  kind = filter_low_1k;
			3'b010:  kind = filter_low_5k;
			3'b011:  kind = filter_low_10k;
			3'b100:  kind = filter_high_1k;
			3'b101:  kind = filter_high_5k;
			3'b110:  kind = filter_high_10k;
			default: kind = filter_none;
		endcase
		return kind;
	endfunction : decode_filter

	wire filter_choice_type next_filter_choice = '{
		z_axis: decode_filter(axis_filter_select[`FILTER_Z_LSB +: 3]),
		y_axis: decode_filter(axis_filter_select[`FILTER_Y_LSB +: 3]),
		x_axis: decode_filter(axis_filter_select[`FILTER_X_LSB +: 3])
	};

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			filter_choice <= '{z_axis: filter_none, y_axis: filter_none, x_axis: filter_none};
		end else begin
			filter_choice <= next_filter_choice;
		end
	end

	// ==========================================
	// Decimated rate selection
	// Outside the three capture modes the stream runs at full rate, so the
	// stored nibbles are ignored rather than applied to real-time data.
	wire logic       rate_modes   = manual_fft_mode || automatic_fft_mode ||
	                                manual_time_capture_mode;
	wire logic       fft_modes    = manual_fft_mode || automatic_fft_mode;
	wire logic [3:0] picked_scale = sample_rate_scale[{rate_setting_index, 2'b00} +: 4];
	wire logic       scale_valid  = (picked_scale >= `FULL_RATE_SCALE) &&
	                                (picked_scale <= `MAX_RATE_SCALE);
	wire logic [3:0] used_scale   = rate_modes ? picked_scale : `FULL_RATE_SCALE;
	wire logic [3:0] shift_wide   = used_scale - `FULL_RATE_SCALE;

	wire rate_choice_type next_rate_choice = '{
		scale:     used_scale,
		applies:   rate_modes,
		valid:     rate_modes ? scale_valid : 1'b1,
		bin_shift: (fft_modes && scale_valid) ? shift_wide[2:0] : 3'b000
	};

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rate_choice <= '{scale: `FULL_RATE_SCALE, applies: 1'b0, valid: 1'b1, bin_shift: 3'b000};
		end else begin
			rate_choice <= next_rate_choice;
		end
	end

endmodule : alarm_filter_rate_config_regs

// *** dv/host_link_model.sv ***
`timescale 1ns/1ps
module host_link_model (
	output logic      link_sclk,
	output logic      link_cs_n,
	output logic      link_mosi,
	input  wire logic link_miso
);
	// ==========================================
	// Serial host
	// The clock idles low between frames so that the device sees exactly sixteen rises a word.
	initial begin
		link_sclk = 1'b0;
		link_cs_n = 1'b1;
		link_mosi = 1'b0;
	end

	task automatic xfer(input logic [15:0] word, output logic [15:0] answer);
		link_cs_n = 1'b0;
		#23;
		for (int k = 15; k >= 0; k--) begin
			link_mosi = word[k];
			#32;
			link_sclk = 1'b1;
			#32;
			link_sclk = 1'b0;
			answer[k] = link_miso;
		end
		#20;
		link_cs_n = 1'b1;
		// A released data line must not keep showing the last bit.
		link_mosi = ~link_mosi;
		#157;
	endtask : xfer
endmodule : host_link_model

// *** dv/alarm_filter_rate_monitor.sv ***
`timescale 1ns/1ps
module alarm_filter_rate_monitor
	import alarm_filter_rate_pkg::*;
(
	input wire logic              clk,
	input wire logic              reset_n,
	input wire logic              link_cs_n,
	input wire logic              link_miso_oe_n,
	input wire logic              measurement_valid,
	input wire logic              record_done,
	input wire logic [5:0]        spectral_exceed,
	input wire logic              manual_fft_mode,
	input wire logic              automatic_fft_mode,
	input wire logic              manual_time_capture_mode,
	input wire logic              alarm_output_one,
	input wire logic              alarm_output_two,
	input wire filter_choice_type filter_choice,
	input wire rate_choice_type   rate_choice,
	input wire logic [15:0]       diagnostic_status
);
	// ==========================================
	// Properties
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);
	logic any_mode;
	assign any_mode = manual_fft_mode | automatic_fft_mode | manual_time_capture_mode;

	pin_one_flag_a: assert property (alarm_output_one |-> |diagnostic_status[10:8])
		else $error("alarm output one high without a level one flag");
	pin_two_flag_a: assert property (alarm_output_two |-> |diagnostic_status[13:11])
		else $error("alarm output two high without a level two flag");
	spectral_cause_a: assert property ($rose(diagnostic_status[8]) |->
		$past(record_done, 2) && $past(spectral_exceed[0], 2))
		else $error("x level one flag rose without an exceeding record");
	system_cause_a: assert property ($rose(diagnostic_status[14]) |-> $past(measurement_valid, 2))
		else $error("system flag rose without a measurement");
	status_reserved_a: assert property (diagnostic_status[15] == 1'b0 && diagnostic_status[7:0] == 8'h00)
		else $error("unused status bits not zero");
	filter_code_a: assert property (filter_choice.x_axis != 3'b111 &&
		filter_choice.y_axis != 3'b111 && filter_choice.z_axis != 3'b111)
		else $error("undefined filter code reached the filter bank");
	rate_applies_a: assert property (rate_choice.applies == $past(any_mode))
		else $error("rate applies flag does not follow the modes");
	rate_idle_a: assert property (!rate_choice.applies |-> rate_choice.scale == 4'h1)
		else $error("rate scale not full rate outside the modes");
	rate_valid_a: assert property (rate_choice.applies |->
		rate_choice.valid == (rate_choice.scale >= 4'h1 && rate_choice.scale <= 4'h7))
		else $error("rate valid flag wrong");
	bin_shift_a: assert property (rate_choice.valid && $past(manual_fft_mode || automatic_fft_mode) |->
		rate_choice.bin_shift == rate_choice.scale[2:0] - 3'h1)
		else $error("bin shift does not match scale");
	output_idle_a: assert property (link_cs_n |-> link_miso_oe_n)
		else $error("serial output driven while frame inactive");

	cover property ($rose(diagnostic_status[14]));
	cover property ($rose(alarm_output_one));
	cover property (rate_choice.applies && rate_choice.valid && rate_choice.bin_shift != 3'h0);
endmodule : alarm_filter_rate_monitor

bind alarm_filter_rate_config_regs alarm_filter_rate_monitor i_monitor (.clk(clk), .reset_n(reset_n),
	.link_cs_n(link_cs_n), .link_miso_oe_n(link_miso_oe_n), .measurement_valid(measurement_valid),
	.record_done(record_done), .spectral_exceed(spectral_exceed), .manual_fft_mode(manual_fft_mode),
	.automatic_fft_mode(automatic_fft_mode), .manual_time_capture_mode(manual_time_capture_mode),
	.alarm_output_one(alarm_output_one), .alarm_output_two(alarm_output_two), .filter_choice(filter_choice),
	.rate_choice(rate_choice), .diagnostic_status(diagnostic_status));

// *** dv/tb_alarm_filter_rate_config_regs.sv ***
`timescale 1ns/1ps
module tb_alarm_filter_rate_config_regs
	import alarm_filter_rate_pkg::*;
;
	logic              clk, reset_n, link_sclk, link_cs_n, link_mosi, link_miso, link_miso_oe_n;
	logic [15:0]       temperature_value, supply_value, diagnostic_status, rv;
	logic              measurement_valid, record_done, alarm_output_one, alarm_output_two;
	logic [5:0]        spectral_exceed;
	logic [1:0]        rate_setting_index;
	logic              manual_fft_mode, automatic_fft_mode, manual_time_capture_mode;
	logic [3:0]        nib;
	logic [2:0]        cx, cy;
	filter_choice_type filter_choice;
	rate_choice_type   rate_choice;
	int                fail_count, n_compared, cycles;

	alarm_filter_rate_config_regs i_dut (.clk(clk), .reset_n(reset_n), .link_sclk(link_sclk),
		.link_cs_n(link_cs_n), .link_mosi(link_mosi), .link_miso(link_miso), .link_miso_oe_n(link_miso_oe_n),
		.temperature_value(temperature_value), .supply_value(supply_value), .measurement_valid(measurement_valid),
		.record_done(record_done), .spectral_exceed(spectral_exceed), .rate_setting_index(rate_setting_index),
		.manual_fft_mode(manual_fft_mode), .automatic_fft_mode(automatic_fft_mode),
		.manual_time_capture_mode(manual_time_capture_mode), .alarm_output_one(alarm_output_one),
		.alarm_output_two(alarm_output_two), .filter_choice(filter_choice), .rate_choice(rate_choice),
		.diagnostic_status(diagnostic_status));
	host_link_model i_host (.link_sclk(link_sclk), .link_cs_n(link_cs_n), .link_mosi(link_mosi),
		.link_miso(link_miso));

	// ==========================================
	// Clock, timeout and tasks
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	// About 16000 cycles are needed; the ceiling leaves generous margin.
	always @(posedge clk) begin
		cycles++;
		if (cycles == 60000) begin
			fail_count++;
			stop_test();
		end
	end

	task automatic stop_test();
		if (fail_count == 0 && n_compared > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : stop_test
	task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	task automatic wait_clk(input int n);
		repeat (n) @(negedge clk);
	endtask : wait_clk
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		logic [15:0] unused;
		i_host.xfer({1'b1, a, d}, unused);
	endtask : wr
	// The answer to a read arrives during the following word.
	task automatic rchk(input string what, input logic [6:0] a, input logic [15:0] exp);
		logic [15:0] seen;
		i_host.xfer({1'b0, a, 8'h00}, seen);
		i_host.xfer(16'h0000, seen);
		chk(what, seen, exp);
	endtask : rchk
	task automatic flag(input int b, input logic e);
		chk("status flag", {15'h0000, diagnostic_status[b]}, {15'h0000, e});
	endtask : flag
	task automatic meas(input logic [15:0] t, input logic [15:0] s, input logic e);
		@(negedge clk);
		temperature_value = t;
		supply_value = s;
		measurement_valid = 1'b1;
		@(negedge clk);
		measurement_valid = 1'b0;
		wait_clk(3);
		flag(14, e);
	endtask : meas
	task automatic rec(input logic [5:0] x);
		@(negedge clk);
		spectral_exceed = x;
		record_done = 1'b1;
		@(negedge clk);
		record_done = 1'b0;
		wait_clk(3);
	endtask : rec

	// ==========================================
	// Scenarios
	initial begin
		{reset_n, measurement_valid, record_done, spectral_exceed, rate_setting_index} = '0;
		{manual_fft_mode, automatic_fft_mode, manual_time_capture_mode} = '0;
		{temperature_value, supply_value} = '0;
		wait_clk(5);
		reset_n = 1'b1;
		wait_clk(4);
		rchk("threshold", 7'h32, 16'h0000);
		rchk("control", 7'h34, 16'h0080);
		rchk("filter", 7'h38, 16'h0000);
		rchk("rate", 7'h3A, 16'h7421);
		chk("filter choice", {7'h00, filter_choice}, 16'h0000);
		chk("rate choice", {7'h00, rate_choice}, 16'h0028);
		wr(7'h38, 8'h71);
		wr(7'h39, 8'h01);
		rchk("filter", 7'h38, 16'h0171);
		chk("filter choice", {7'h00, filter_choice}, 16'h0041);
		wr(7'h39, 8'hFF);
		rchk("filter", 7'h38, 16'h0771);
		for (int c = 0; c < 8; c++) begin
			wr(7'h38, {1'b0, 3'(7 - c), 1'b0, 3'(c)});
			cx = (c == 7) ? 3'h0 : 3'(c);
			cy = (c == 0) ? 3'h0 : 3'(7 - c);
			chk("filter choice", {7'h00, filter_choice}, {7'h00, 3'h0, cy, cx});
		end
		wr(7'h3B, 8'h35);
		rchk("rate", 7'h3A, 16'h3521);
		rv = 16'h3521;
		wait_clk(1);
		manual_fft_mode = 1'b1;
		for (int i = 0; i < 4; i++) begin
			rate_setting_index = 2'(i);
			nib = rv[i*4 +: 4];
			wait_clk(2);
			chk("rate choice", {7'h00, rate_choice}, {7'h00, nib, 2'b11, nib[2:0] - 3'h1});
		end
		manual_fft_mode = 1'b0;
		manual_time_capture_mode = 1'b1;
		rate_setting_index = 2'h2;
		wait_clk(2);
		chk("rate choice", {7'h00, rate_choice}, 16'h00B8);
		manual_time_capture_mode = 1'b0;
		automatic_fft_mode = 1'b1;
		wr(7'h3A, 8'h00);
		rate_setting_index = 2'h0;
		wait_clk(2);
		chk("rate valid", {15'h0000, rate_choice.valid}, 16'h0000);
		automatic_fft_mode = 1'b0;
		wait_clk(2);
		chk("rate idle", {11'h000, rate_choice.scale, rate_choice.applies}, 16'h0002);
		wr(7'h32, 8'h00);
		wr(7'h33, 8'h01);
		wr(7'h34, 8'h08);
		meas(16'h0000, 16'h0200, 1'b1);
		meas(16'h0000, 16'h0050, 1'b0);
		wr(7'h34, 8'h28);
		meas(16'h0000, 16'h0050, 1'b1);
		wr(7'h34, 8'h38);
		meas(16'hFFFB, 16'h0200, 1'b1);
		wr(7'h34, 8'h18);
		meas(16'hFFFB, 16'h0050, 1'b0);
		wr(7'h34, 8'h10);
		meas(16'h0200, 16'h0200, 1'b0);
		wr(7'h34, 8'h98);
		meas(16'h0200, 16'h0000, 1'b1);
		meas(16'h0000, 16'h0000, 1'b1);
		wr(7'h3E, 8'h10);
		flag(14, 1'b0);
		wr(7'h35, 8'h02);
		wr(7'h34, 8'h41);
		for (int k = 0; k < 3; k++) begin
			rec(6'h01);
			flag(8, k == 2);
		end
		chk("alarm one", {15'h0000, alarm_output_one}, 16'h0001);
		rec(6'h02);
		flag(9, 1'b0);
		wr(7'h34, 8'hC1);
		repeat (3) rec(6'h01);
		rchk("status", 7'h3C, 16'h0100);
		rchk("status", 7'h3C, 16'h0000);
		wr(7'h35, 8'h12);
		repeat (3) rec(6'h01);
		rchk("status", 7'h3C, 16'h0100);
		rchk("status", 7'h3C, 16'h0100);
		repeat (3) rec(6'h08);
		flag(11, 1'b1);
		chk("alarm two", {15'h0000, alarm_output_two}, 16'h0001);
		wr(7'h34, 8'h81);
		chk("alarm two", {15'h0000, alarm_output_two}, 16'h0000);
		wr(7'h10, 8'hAA);
		rchk("unmapped", 7'h10, 16'h0000);
		stop_test();
	end
endmodule : tb_alarm_filter_rate_config_regs
